// ### design/parallel_port_mode_and_gpio_mux.sv
// pin mux for the shared parallel port, external flag and general io
// assumes access requests come from the core and are synchronous to mclk_in
`timescale 1ns/1ps
module parallel_port_mode_and_gpio_mux
  import pin_mux_pkg::*;
#(
  parameter int GPIO_N = pin_mux_pkg::GPIO_WIDTH
) (
  // clock and reset
  input  wire logic                               mclk_in,
  input  wire logic                               srst_in,
  // mode straps
  input  wire logic                               port_mode_select_in,
  input  wire logic                               host_mode_select_in,
  input  wire logic                               subsystem_select_in,
  input  wire logic                               global_off_n_in,
  // core access request
  input  wire pin_mux_pkg::access_type            access_in,
  input  wire logic                               access_from_b_in,
  // software control
  input  wire logic                               flag_wr_in,
  input  wire logic                               flag_val_in,
  input  wire logic                               io_wr_in,
  input  wire pin_mux_pkg::io_ctrl_type           io_ctrl_in,
  input  wire logic                               timer_in,
  // io pins
  input  wire logic [pin_mux_pkg::GPIO_WIDTH-1:0] io_pin_in,
  output logic [pin_mux_pkg::GPIO_WIDTH-1:0]      io_pin_out,
  output logic [pin_mux_pkg::GPIO_WIDTH-1:0]      io_pin_oe_out,
  output logic [pin_mux_pkg::GPIO_WIDTH-1:0]      io_read_out,
  output logic                                    branch_condition_input_out,
  // subsystem b io pin 3 on the io space select pin
  input  wire logic                               io_select_pin_in,
  // strobe pins
  input  wire logic                               prog_select_pin_in,
  input  wire logic                               data_select_pin_in,
  output pin_mux_pkg::strobe_type                 strobe_out,
  output pin_mux_pkg::strobe_type                 strobe_oe_out,
  output logic                                    host_strobe_one_out,
  output logic                                    host_strobe_two_out,
  output logic                                    sub_b_io_pin_three_out,
  // flag and mode status
  output logic                                    external_flag_out,
  output logic                                    external_flag_oe_out,
  output logic                                    host_port_active_out,
  output logic                                    micro_mode_bit_out,
  output logic                                    ext_owner_b_out,
  output logic                                    fetch_start_out,
  output logic [17:0]                             fetch_addr_out,
  output logic                                    cpu_halt_out
);
  import pin_mux_pkg::*;

  // port widths follow the package, so a different pin count cannot be served
  if (GPIO_N != GPIO_WIDTH) begin : g_bad_width
    $error("GPIO_N must equal GPIO_WIDTH");
  end
  // the timer and branch pins must be two distinct io pins
  if (TIMER_PIN >= GPIO_N) begin : g_bad_timer_pin
    $error("TIMER_PIN lies outside the io pins");
  end
  if (BRANCH_PIN >= GPIO_N) begin : g_bad_branch_pin
    $error("BRANCH_PIN lies outside the io pins");
  end
  if (TIMER_PIN == BRANCH_PIN) begin : g_bad_pin_share
    $error("TIMER_PIN and BRANCH_PIN must differ");
  end

  typedef struct packed {
    logic       flag;
    logic       micro_mode;
    logic       in_reset;
    logic       fetch_start;
    logic       timer_sel;
    logic       b3_dir;
    logic       b3_val;
    strobe_type strobes;
  } mux_state_type;

  mux_state_type state_r;
  mux_state_type state_nxt;

  logic                  host_mode;
  logic                  access_ours;
  logic                  b3_drive;
  logic [GPIO_WIDTH-1:0] cell_out;
  logic [GPIO_WIDTH-1:0] cell_oe;
  logic [GPIO_WIDTH-1:0] cell_rd;

  assign host_mode = ~port_mode_select_in;
  assign access_ours = (access_from_b_in == subsystem_select_in);

  genvar gi;
  generate
    for (gi = 0; gi < GPIO_WIDTH; gi++) begin : g_cell
      io_pin_cell u_cell (
        .mclk_in      (mclk_in),
        .srst_in      (srst_in),
        .wr_in        (io_wr_in),
        .dir_in       (io_ctrl_in.dir[gi]),
        .val_in       (io_ctrl_in.val[gi]),
        .pin_level_in (io_pin_in[gi]),
        .pin_out      (cell_out[gi]),
        .pin_oe_out   (cell_oe[gi]),
        .rd_level_out (cell_rd[gi])
      );
    end
  endgenerate

  always_comb begin
    state_nxt             = state_r;
    state_nxt.fetch_start = 1'b0;
    state_nxt.in_reset    = 1'b0;
    if (state_r.in_reset) begin
      state_nxt.fetch_start = 1'b1;
    end
    if (flag_wr_in) begin
      state_nxt.flag = flag_val_in;
    end
    if (io_wr_in) begin
      state_nxt.timer_sel = io_ctrl_in.timer_output_select;
      state_nxt.b3_dir    = io_ctrl_in.dir[TIMER_PIN];
      state_nxt.b3_val    = io_ctrl_in.val[TIMER_PIN];
    end
    state_nxt.strobes = '{default: STROBE_IDLE};
    if (!host_mode && access_ours) begin
      case (access_in)
        ACC_PROG: begin
          state_nxt.strobes.program_space_select_n = 1'b0;
          state_nxt.strobes.memory_strobe_n        = 1'b0;
        end
        ACC_DATA: begin
          state_nxt.strobes.data_space_select_n = 1'b0;
          state_nxt.strobes.memory_strobe_n     = 1'b0;
        end
        ACC_IO: begin
          state_nxt.strobes.io_space_select_n = 1'b0;
        end
        ACC_IDLE: begin
          state_nxt.strobes = '{default: STROBE_IDLE};
        end
        default: begin
          state_nxt.strobes = '{default: STROBE_IDLE};
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_r          <= '0;
      state_r.strobes  <= '{default: STROBE_IDLE};
      state_r.in_reset <= 1'b1;
      // strap combination sampled while reset is held
      state_r.micro_mode <= port_mode_select_in & ~host_mode_select_in
                            & ~subsystem_select_in;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign strobe_out = state_r.strobes;

  always_comb begin
    strobe_oe_out = '0;
    if (global_off_n_in) begin
      // host mode: program and data selects are host inputs
      strobe_oe_out.program_space_select_n = ~host_mode;
      strobe_oe_out.data_space_select_n    = ~host_mode;
      // io select pin drives as io strobe in memory mode, in host mode only as sub b output
      strobe_oe_out.io_space_select_n      = b3_drive;
      strobe_oe_out.memory_strobe_n        = 1'b1;
    end
  end
  // host strobes driven by host; selects not driven
  assign host_strobe_one_out = host_mode ? prog_select_pin_in : 1'b1;
  assign host_strobe_two_out = host_mode ? data_select_pin_in : 1'b1;

  always_comb begin
    io_pin_out    = cell_out;
    io_pin_oe_out = cell_oe;
    io_read_out   = cell_rd;
    if (host_mode && !host_mode_select_in && state_r.timer_sel) begin
      io_pin_out[TIMER_PIN]    = timer_in;
      io_pin_oe_out[TIMER_PIN] = 1'b1;
    end
    // memory mode keeps pin 3 as strobe
    if (!host_mode) begin
      io_pin_oe_out[TIMER_PIN] = global_off_n_in;
      io_pin_out[TIMER_PIN]    = state_r.strobes.io_space_select_n;
    end
  end

  always_comb begin
    b3_drive               = 1'b1;
    sub_b_io_pin_three_out = state_r.strobes.io_space_select_n;
    // io select pin becomes sub b pin 3
    if (host_mode) begin
      b3_drive               = state_r.timer_sel | state_r.b3_dir;
      sub_b_io_pin_three_out = state_r.b3_val;
      if (state_r.timer_sel) begin
        sub_b_io_pin_three_out = timer_in;
      end else if (!state_r.b3_dir) begin
        // a released pin echoes its own level; enabling the driver switches it to b3_val, latched by the same write
        sub_b_io_pin_three_out = io_select_pin_in;
      end
    end
  end

  // branch condition from pin 2 as input
  assign branch_condition_input_out = cell_oe[BRANCH_PIN] ? 1'b1 : io_pin_in[BRANCH_PIN];
  assign external_flag_out    = state_r.flag;
  assign external_flag_oe_out = global_off_n_in;
  assign host_port_active_out = host_mode;
  assign micro_mode_bit_out   = state_r.micro_mode;
  assign ext_owner_b_out      = subsystem_select_in;
  assign fetch_start_out      = state_r.fetch_start;
  assign fetch_addr_out       = RESET_VECTOR;
  assign cpu_halt_out         = srst_in;
endmodule

// ### design/pin_mux_pkg.sv
// shared constants and carrier structs for the parallel port pin mux
// assumes one 40 MHz clock, synchronous active-high reset, no register bus
//
// Behaviour
// - while reset is held, execution stops and all control state reinitialises
// - on reset release, fetching starts at program address 0FF80h
// - port mode pin low selects the host port interface
// - port mode pin high selects the external memory interface
// - micro mode bit initial value comes from port, host and subsystem pins
// - external flag pin is output only, a latched software-set bit
// - global off low floats flag, space selects and memory strobe
// - io register write latches values, driven on pins set as outputs
// - io register read returns pin levels for pins set as inputs
// - each io pin has its own direction field
// - io pin 2 as input also gives the branch condition
// - host mode, multiplexed: io pin 3 follows the io control register
// - timer select 1 drives timer on pin 3 while host mode pin is low, 0 keeps plain io
// - memory mode: pin 3 shares act as I/O strobe during io accesses
// - program space select asserted throughout external program accesses
// - data space select asserted throughout external data accesses
// - io space select asserted throughout external io accesses
// - host mode: program and data selects become host strobe inputs
// - host mode: io space select pin becomes subsystem B io pin 3
// - memory strobe active only in memory mode for program or data transfers
// - memory mode: subsystem select low gives A the interface, high gives B
package pin_mux_pkg;

  localparam int          GPIO_WIDTH     = 4;
  localparam logic [17:0] RESET_VECTOR   = 18'h0_FF80;
  localparam logic        STROBE_IDLE    = 1'b1;
  localparam int          TIMER_PIN      = 3;
  localparam int          BRANCH_PIN     = 2;

  typedef enum logic [3:0] {
    ACC_IDLE = 4'b0001,
    ACC_PROG = 4'b0010,
    ACC_DATA = 4'b0100,
    ACC_IO   = 4'b1000
  } access_type;

  typedef struct packed {
    logic [GPIO_WIDTH-1:0] dir;
    logic [GPIO_WIDTH-1:0] val;
    logic                  timer_output_select;
  } io_ctrl_type;

  typedef struct packed {
    logic       program_space_select_n;
    logic       data_space_select_n;
    logic       io_space_select_n;
    logic       memory_strobe_n;
  } strobe_type;

endpackage

// ### design/io_pin_cell.sv
// one general purpose io pin: latched output value and direction
// assumes synchronous inputs on mclk_in
`timescale 1ns/1ps
module io_pin_cell (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic srst_in,
  // software write
  input  wire logic wr_in,
  input  wire logic dir_in,
  input  wire logic val_in,
  // pin
  input  wire logic pin_level_in,
  output logic      pin_out,
  output logic      pin_oe_out,
  output logic      rd_level_out
);
  typedef struct packed {
    logic dir;
    logic val;
  } cell_state_type;

  cell_state_type state_r;
  cell_state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (wr_in) begin
      state_nxt.dir = dir_in;
      state_nxt.val = val_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pin_out    = state_r.val;
  assign pin_oe_out = state_r.dir;
  // inputs read pin level, outputs read latch
  assign rd_level_out = state_r.dir ? state_r.val : pin_level_in;
endmodule

// ### tb/pin_mux_checker.sv
// port assertions for the parallel port pin mux
// assumes bind onto the top module, one clock domain
`timescale 1ns/1ps
module pin_mux_checker
  import pin_mux_pkg::*;
(
  // clock and reset
  input wire logic                     mclk_in,
  input wire logic                     srst_in,
  // straps and requests
  input wire logic                     port_mode_select_in,
  input wire logic                     subsystem_select_in,
  input wire logic                     global_off_n_in,
  input wire pin_mux_pkg::access_type  access_in,
  input wire logic                     access_from_b_in,
  input wire logic                     flag_wr_in,
  input wire logic                     flag_val_in,
  input wire logic                     io_wr_in,
  input wire pin_mux_pkg::io_ctrl_type io_ctrl_in,
  // watched outputs
  input wire pin_mux_pkg::strobe_type  strobe_out,
  input wire pin_mux_pkg::strobe_type  strobe_oe_out,
  input wire logic                     external_flag_out,
  input wire logic                     external_flag_oe_out,
  input wire logic                     fetch_start_out,
  input wire logic [17:0]              fetch_addr_out,
  input wire logic [3:0]               io_pin_out,
  input wire logic [3:0]               io_pin_oe_out
);
  import pin_mux_pkg::*;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  logic own;

  assign own = port_mode_select_in && (access_from_b_in == subsystem_select_in);

  a_prog_strobe: assert property (own && access_in == ACC_PROG |=> strobe_out == 4'h6)
    else $error("program access strobes wrong");
  a_data_strobe: assert property (own && access_in == ACC_DATA |=> strobe_out == 4'hA)
    else $error("data access strobes wrong");
  a_io_strobe: assert property (own && access_in == ACC_IO |=> strobe_out == 4'hD)
    else $error("io access strobes wrong");
  a_host_quiet: assert property (!port_mode_select_in |=> strobe_out.memory_strobe_n)
    else $error("memory strobe active in host mode");
  a_idle_high: assert property (port_mode_select_in && access_in == ACC_IDLE
    |=> strobe_out == 4'hF)
    else $error("strobe low while idle");
  a_off_float: assert property (!global_off_n_in
    |-> strobe_oe_out == 4'h0 && !external_flag_oe_out)
    else $error("pins driven while off");
  a_fetch_vector: assert property ($fell(srst_in)
    |-> ##[0:1] (fetch_start_out && fetch_addr_out == RESET_VECTOR))
    else $error("no fetch start at vector");
  a_flag_latch: assert property (flag_wr_in |=> external_flag_out == $past(flag_val_in))
    else $error("flag not latched");
  a_dir_latch: assert property (io_wr_in
    |=> io_pin_oe_out[2:0] == $past(io_ctrl_in.dir[2:0]))
    else $error("direction not latched");
  a_pin3_strobe: assert property (port_mode_select_in
    |-> io_pin_out[3] == strobe_out.io_space_select_n)
    else $error("pin 3 not following io strobe");
  c_io_access: cover property (own && access_in == ACC_IO);
  c_off: cover property (!global_off_n_in);
  c_io_write: cover property (io_wr_in);
endmodule
bind parallel_port_mode_and_gpio_mux pin_mux_checker i_chk (
  .mclk_in              (mclk_in),
  .srst_in              (srst_in),
  .port_mode_select_in  (port_mode_select_in),
  .subsystem_select_in  (subsystem_select_in),
  .global_off_n_in      (global_off_n_in),
  .access_in            (access_in),
  .access_from_b_in     (access_from_b_in),
  .flag_wr_in           (flag_wr_in),
  .flag_val_in          (flag_val_in),
  .io_wr_in             (io_wr_in),
  .io_ctrl_in           (io_ctrl_in),
  .strobe_out           (strobe_out),
  .strobe_oe_out        (strobe_oe_out),
  .external_flag_out    (external_flag_out),
  .external_flag_oe_out (external_flag_oe_out),
  .fetch_start_out      (fetch_start_out),
  .fetch_addr_out       (fetch_addr_out),
  .io_pin_out           (io_pin_out),
  .io_pin_oe_out        (io_pin_oe_out)
);

// ### tb/far_side_model.sv
// far side of the port: host strobes and levels on the io wires
// assumes bench commands settle between clock edges
`timescale 1ns/1ps
module far_side_model (
  // commands
  input  wire logic       host_mode_in,
  input  wire logic       hs1_req_in,
  input  wire logic       hs2_req_in,
  input  wire logic [3:0] ext_level_in,
  // device pins
  input  wire logic [3:0] io_drive_in,
  input  wire logic [3:0] io_oe_in,
  output logic            prog_pin_out,
  output logic            data_pin_out,
  output logic [3:0]      io_level_out
);
  // host drives strobes, pull-up level otherwise
  assign prog_pin_out = host_mode_in ? ~hs1_req_in : 1'h1;
  assign data_pin_out = host_mode_in ? ~hs2_req_in : 1'h1;
  // device drive wins on every enabled wire
  assign io_level_out = (io_oe_in & io_drive_in) | (~io_oe_in & ext_level_in);
endmodule

// ### tb/parallel_port_mode_and_gpio_mux_bench.sv
// self-checking bench for the parallel port pin mux
// assumes the checker and far_side_model are compiled first
`timescale 1ns/1ps
module parallel_port_mode_and_gpio_mux_bench;
  import pin_mux_pkg::*;
  logic        mclk_in = 1'h0, srst_in = 1'h1, pm = 1'h1, hm = 1'h0, sel = 1'h0;
  logic        off_n = 1'h1, from_b = 1'h0, fw = 1'h0, fv = 1'h0, iw = 1'h0;
  logic        tmr = 1'h0, hs1 = 1'h0, hs2 = 1'h0, ps_pin, ds_pin, brc, h1, h2;
  logic        b3i = 1'h0, b3o;
  logic        flag, flag_oe, hpa, mm, ob, fs, halt;
  logic [3:0]  ext = 4'h0, pin, po, poe, rd;
  logic [17:0] fa;
  access_type  acc = ACC_IDLE;
  io_ctrl_type ctl = 9'h000;
  strobe_type  stb, stb_oe;
  int          n_errors = 0, checks = 0, i, k;
  access_type  kd[7] = '{ACC_PROG, ACC_DATA, ACC_IO, ACC_PROG, ACC_PROG, ACC_IDLE, ACC_DATA};
  logic [3:0]  ex[7] = '{4'h6, 4'hA, 4'hD, 4'hF, 4'h6, 4'hF, 4'hF};
  logic [1:0]  sf[7] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h3, 2'h1};

  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  far_side_model i_far (.host_mode_in(~pm), .hs1_req_in(hs1), .hs2_req_in(hs2),
    .ext_level_in(ext), .io_drive_in(po), .io_oe_in(poe), .prog_pin_out(ps_pin),
    .data_pin_out(ds_pin), .io_level_out(pin));

  parallel_port_mode_and_gpio_mux i_dut (.mclk_in(mclk_in), .srst_in(srst_in),
    .port_mode_select_in(pm), .host_mode_select_in(hm), .subsystem_select_in(sel),
    .global_off_n_in(off_n), .access_in(acc), .access_from_b_in(from_b),
    .flag_wr_in(fw), .flag_val_in(fv), .io_wr_in(iw), .io_ctrl_in(ctl), .timer_in(tmr),
    .io_pin_in(pin), .io_pin_out(po), .io_pin_oe_out(poe), .io_read_out(rd),
    .branch_condition_input_out(brc), .io_select_pin_in(b3i),
    .prog_select_pin_in(ps_pin), .data_select_pin_in(ds_pin), .strobe_out(stb),
    .strobe_oe_out(stb_oe), .host_strobe_one_out(h1), .host_strobe_two_out(h2),
    .sub_b_io_pin_three_out(b3o), .external_flag_out(flag), .external_flag_oe_out(flag_oe),
    .host_port_active_out(hpa), .micro_mode_bit_out(mm), .ext_owner_b_out(ob),
    .fetch_start_out(fs), .fetch_addr_out(fa), .cpu_halt_out(halt));

  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask

  task automatic chk(input logic [17:0] exp, input logic [17:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: exp %h got %h", $time, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic rst(input int n);
    srst_in = 1'h1;
    step(n);
    chk(1'h1, halt);
    chk(4'hF, stb);
    chk(pm & ~hm & ~sel, mm);
    srst_in = 1'h0;
    for (k = 0; k < 3; k++) begin
      step();
      if (fs === 1'h1) break;
    end
    chk(1'h1, fs);
    chk(18'h0_FF80, fa);
    if (fs !== 1'h1) final_report();
  endtask

  initial begin
    #2;
    for (i = 0; i < 8; i++) begin
      {pm, hm, sel} = i[2:0];
      rst(i == 0 ? 8 : 2);
    end
    {pm, hm, sel} = 3'h4;
    $display("test reset done");
    for (i = 0; i < 7; i++) begin
      acc = kd[i];
      {sel, from_b} = sf[i];
      step();
      chk(ex[i], stb);
      chk(sel, ob);
      chk(ex[i][1], po[3]);
    end
    chk(1'h0, hpa);
    chk(4'hF, stb_oe);
    chk(2'h3, {h1, h2});
    $display("test memory mode done");
    pm = 1'h0;
    acc = ACC_PROG;
    from_b = 1'h0;
    hs1 = 1'h1;
    step();
    chk(1'h1, stb.memory_strobe_n);
    chk(4'h1, stb_oe);
    chk(1'h1, hpa);
    chk(2'h1, {h1, h2});
    {hs1, hs2} = 2'h1;
    step();
    chk(2'h2, {h1, h2});
    $display("test host mode done");
    {fw, fv} = 2'h3;
    step();
    fw = 1'h0;
    off_n = 1'h0;
    step();
    chk(1'h1, flag);
    chk(5'h00, {stb_oe, flag_oe});
    off_n = 1'h1;
    $display("test flag done");
    {hs2, acc, ext, ctl} = {1'h0, ACC_IDLE, 4'hC, 4'h3, 4'h5, 1'h0};
    iw = 1'h1;
    step();
    iw = 1'h0;
    step();
    chk(4'h3, poe);
    chk(2'h1, po[1:0]);
    chk(4'hD, rd);
    chk(1'h1, brc);
    ext = 4'h8;
    b3i = 1'h1;
    step(2);
    chk(1'h0, brc);
    chk(4'h9, rd);
    chk(1'h1, b3o);
    {iw, tmr, ctl} = {2'h3, 4'hB, 4'h0, 1'h1};
    step();
    iw = 1'h0;
    step();
    chk(1'h1, po[3]);
    chk(4'h3, stb_oe);
    hm = 1'h1;
    step();
    chk(1'h0, po[3]);
    {hm, tmr} = 2'h0;
    step(2);
    chk(1'h0, po[3]);
    chk(1'h0, b3o);
    {iw, ctl} = {1'h1, 4'h8, 4'h8, 1'h0};
    step();
    iw = 1'h0;
    step();
    chk(1'h1, po[3]);
    chk(1'h1, b3o);
    $display("test general io done");
    final_report();
  end
endmodule
